// ### design/wdg_pkg.sv
// Constants, types and helpers shared by the watchdog core and its tick sampler.
// Assumes a 10 MHz system clock and an 8-bit register port with an 8-bit address.
package wdg_pkg;

  // ==========================================================================
  // Clock figures
  // ==========================================================================
  localparam int unsigned SYS_CLK_HZ    = 10_000_000;
  localparam int unsigned RC_CLK_HZ     = 10_000;
  localparam int unsigned TA_WINDOW_NS  = 400;
  localparam int unsigned TA_WINDOW_CYC = (TA_WINDOW_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] ADDR_RESET_CONTROL = 8'hab;
  localparam logic [7:0] ADDR_MAIN_CONTROL  = 8'hd8;
  localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'he8;
  localparam logic [7:0] ADDR_TIMED_ACCESS  = 8'hc7;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned BIT_ENABLE      = 7;
  localparam int unsigned BIT_CLEAR       = 6;
  localparam int unsigned BIT_TIMEOUT     = 5;
  localparam int unsigned BIT_RUN_LP      = 4;
  localparam int unsigned BIT_RESET_FLAG  = 3;
  localparam int unsigned BIT_PS_HI       = 2;
  localparam int unsigned BIT_RST_EN      = 0;
  localparam int unsigned BIT_TIMEOUT_IRQ = 4;

  // ==========================================================================
  // Reset values, keys and counts
  // ==========================================================================
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  localparam logic [2:0]  PS_RESET       = 3'h0;
  localparam logic [7:0]  TA_KEY_FIRST   = 8'haa;
  localparam logic [7:0]  TA_KEY_SECOND  = 8'h55;
  localparam int unsigned BASE_SHIFT     = 6;
  localparam int unsigned CNT_W          = 14;
  localparam int unsigned GRACE_TICKS    = 512;
  localparam int unsigned GRACE_W        = 9;
  localparam logic [GRACE_W-1:0] GRACE_LAST = 9'h1ff;
  localparam logic [CNT_W-1:0]   CNT_ZERO   = 14'h0000;

  typedef enum logic [1:0] {
    WDG_TA_LOCKED,
    WDG_TA_FIRST_SEEN,
    WDG_TA_OPEN
  } wdg_ta_t;

  // Last count before time-out for a prescale code: 64 times 1, 2, 8 .. 256, minus one.
  function automatic logic [CNT_W-1:0] wdg_last_count(input logic [2:0] ps);
    logic [3:0] shift;
    shift = 4'h0;
    unique case (ps)
      3'h0: shift = 4'h6;
      3'h1: shift = 4'h7;
      3'h2: shift = 4'h9;
      3'h3: shift = 4'ha;
      3'h4: shift = 4'hb;
      3'h5: shift = 4'hc;
      3'h6: shift = 4'hd;
      3'h7: shift = 4'he;
    endcase
    return CNT_W'((15'h0001 << shift) - 15'h0001);
  endfunction : wdg_last_count

endpackage : wdg_pkg

// ### design/wdg_tick_sync.sv
// Turns the free-running low-speed RC clock pin into one-cycle ticks on the system clock.
// Assumes the RC clock is far slower than the system clock.
`timescale 1ns/100ps
module wdg_tick_sync
  import wdg_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic reset_i,
  input  wire logic rc_clk_i,
  output logic      tick_o
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // ==========================================================================
  // Two-stage synchroniser and rising-edge detector
  // ==========================================================================
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= rc_clk_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign tick_o = sync_r && !prev_r;

endmodule : wdg_tick_sync

// ### design/wdg_core.sv
// Watchdog counter with prescaled time-out, interrupt flag, wake-up and reset grace window.
// Assumes a synchronous register port, a separate power-on reset input and CPU mode inputs
// driven from the same clock domain.
//
// Notes on behaviour
// - Writing one to the clear bit zeroes the counter; the bit reads zero.
// - Clearing the enable bit stops the watchdog and zeroes its counter.
// - With enable set the counter advances on each low-speed RC clock.
// - Prescale code selects time-out of 64 clocks times 1,2,8,16,32,64,128,256.
// - An expired interval sets the time-out flag in hardware.
// - Interrupt request is flag AND the enable bit 4 of the interrupt enable register.
// - Every time-out gives a wake-up pulse out of idle or power-down.
// - With reset enable set, 512 RC clocks after time-out without clear reset the system.
// - Reset flag set by watchdog reset, cleared by power-on only, software may clear.
// - Every reset loads the enable bit with the inverse of the configuration bit.
// - Counter holds in low-power modes unless run-in-low-power is set.
// - Entering or leaving idle or power-down zeroes the counter.
// - Run-in-low-power and prescale survive all resets except power-on.
// - Reset enable sits in bit 0 of the reset control register, power-on cleared.
// - Both control registers need a timed-access unlock; other writes are ignored.
// - Counting uses the RC clock pin, sampled into one-cycle ticks on the system clock.
`timescale 1ns/100ps
module wdg_core
  import wdg_pkg::*;
#(
  parameter int unsigned TA_WINDOW = TA_WINDOW_CYC
)
(
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic       por_i,
  input  wire logic       rc_clk_i,
  input  wire logic       config_watchdog_disable_i,
  input  wire logic       cpu_idle_i,
  input  wire logic       cpu_powerdown_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic            irq_o,
  output logic            wake_o,
  output logic            sys_reset_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic               watchdog_enable;
    logic               run_in_low_power;
    logic               timeout_flag;
    logic               watchdog_reset_flag;
    logic [2:0]         prescale_select;
    logic               reset_on_timeout_enable;
    logic [7:0]         irq_enable_reg;
    logic [CNT_W-1:0]   count;
    logic               grace_active;
    logic [GRACE_W-1:0] grace;
    wdg_ta_t            ta_state;
    logic [2:0]         ta_cnt;
    logic               low_power_prev;
    logic               wake;
    logic               sys_reset;
    logic [7:0]         rdata;
  } wdg_state_t;

  wdg_state_t st_r;
  wdg_state_t st_nxt;

  logic tick;
  logic low_power;
  logic unlocked;
  logic wr_main;
  logic wr_main_ok;
  logic wr_rst_ok;
  logic clear_req;
  logic run;
  logic timeout;
  logic grace_expire;

  // ==========================================================================
  // RC clock sampling
  // ==========================================================================
  wdg_tick_sync u_tick (
    .clock_i  (clock_i),
    .reset_i  (por_i),
    .rc_clk_i (rc_clk_i),
    .tick_o   (tick)
  );

  // ==========================================================================
  // Decodes
  // ==========================================================================
  assign low_power    = cpu_idle_i || cpu_powerdown_i;
  assign unlocked     = (st_r.ta_state == WDG_TA_OPEN);
  assign wr_main      = wr_i && (addr_i == ADDR_MAIN_CONTROL);
  assign wr_main_ok   = wr_main && unlocked;
  assign wr_rst_ok    = wr_i && (addr_i == ADDR_RESET_CONTROL) && unlocked;
  assign clear_req    = (wr_main_ok && wdata_i[BIT_CLEAR])
                     || (wr_main_ok && !wdata_i[BIT_ENABLE])
                     || (low_power != st_r.low_power_prev);
  assign run          = st_r.watchdog_enable && tick && (!low_power || st_r.run_in_low_power);
  // Greater-or-equal catches a count left above a newly chosen shorter interval.
  assign timeout      = run && !clear_req && (st_r.count >= wdg_last_count(st_r.prescale_select));
  assign grace_expire = run && !clear_req && st_r.grace_active && (st_r.grace == GRACE_LAST);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    st_nxt      = st_r;
    st_nxt.wake = 1'b0;
    st_nxt.sys_reset = 1'b0;
    st_nxt.low_power_prev = low_power;

    // Timed-access unlock sequencer.
    if (st_r.ta_state != WDG_TA_LOCKED) begin
      st_nxt.ta_cnt = st_r.ta_cnt + 3'h1;
      if (32'(st_r.ta_cnt) + 1 >= TA_WINDOW) begin
        st_nxt.ta_state = WDG_TA_LOCKED;
      end
    end
    if (wr_i) begin
      if (addr_i == ADDR_TIMED_ACCESS && wdata_i == TA_KEY_FIRST) begin
        st_nxt.ta_state = WDG_TA_FIRST_SEEN;
        st_nxt.ta_cnt   = 3'h0;
      end else if (addr_i == ADDR_TIMED_ACCESS && wdata_i == TA_KEY_SECOND
                   && st_r.ta_state == WDG_TA_FIRST_SEEN) begin
        st_nxt.ta_state = WDG_TA_OPEN;
        st_nxt.ta_cnt   = 3'h0;
      end else begin
        st_nxt.ta_state = WDG_TA_LOCKED;
      end
    end

    // Register writes.
    if (wr_main_ok) begin
      st_nxt.watchdog_enable     = wdata_i[BIT_ENABLE];
      st_nxt.timeout_flag        = wdata_i[BIT_TIMEOUT];
      st_nxt.run_in_low_power    = wdata_i[BIT_RUN_LP];
      st_nxt.watchdog_reset_flag = wdata_i[BIT_RESET_FLAG];
      st_nxt.prescale_select     = wdata_i[BIT_PS_HI:0];
    end
    if (wr_rst_ok) begin
      st_nxt.reset_on_timeout_enable = wdata_i[BIT_RST_EN];
    end
    if (wr_i && addr_i == ADDR_IRQ_ENABLE) begin
      st_nxt.irq_enable_reg = wdata_i;
    end

    // Counter, time-out and grace window.
    if (clear_req) begin
      st_nxt.count        = CNT_ZERO;
      st_nxt.grace_active = 1'b0;
      st_nxt.grace        = '0;
    end else if (run) begin
      if (timeout) begin
        st_nxt.count        = CNT_ZERO;
        st_nxt.timeout_flag = 1'b1;
        st_nxt.wake         = 1'b1;
        if (st_r.reset_on_timeout_enable && !st_r.grace_active) begin
          st_nxt.grace_active = 1'b1;
          st_nxt.grace        = '0;
        end
      end else begin
        st_nxt.count = st_r.count + 14'h0001;
      end
      if (st_r.grace_active) begin
        if (grace_expire) begin
          st_nxt.sys_reset           = 1'b1;
          st_nxt.watchdog_reset_flag = 1'b1;
          st_nxt.grace_active        = 1'b0;
          st_nxt.grace               = '0;
        end else begin
          st_nxt.grace = st_r.grace + 9'h001;
        end
      end
    end

    // Read data, valid only in the cycle after the read strobe.
    st_nxt.rdata = RESET_BYTE;
    if (rd_i) begin
      unique case (addr_i)
        ADDR_MAIN_CONTROL: st_nxt.rdata = {st_r.watchdog_enable, 1'b0, st_r.timeout_flag,
                                           st_r.run_in_low_power, st_r.watchdog_reset_flag,
                                           st_r.prescale_select};
        ADDR_RESET_CONTROL: st_nxt.rdata = {7'h00, st_r.reset_on_timeout_enable};
        ADDR_IRQ_ENABLE:    st_nxt.rdata = st_r.irq_enable_reg;
        default:            st_nxt.rdata = RESET_BYTE;
      endcase
    end

    // Resets: power-on clears all but the enable bit and low_power_prev, other resets keep the retained fields.
    if (por_i) begin
      st_nxt = '0;
      st_nxt.prescale_select = PS_RESET;
      st_nxt.watchdog_enable = !config_watchdog_disable_i;
      st_nxt.low_power_prev  = low_power;
      st_nxt.ta_state        = WDG_TA_LOCKED;
    end else if (reset_i) begin
      st_nxt.watchdog_enable = !config_watchdog_disable_i;
      st_nxt.timeout_flag    = 1'b0;
      st_nxt.irq_enable_reg  = RESET_BYTE;
      st_nxt.count           = CNT_ZERO;
      st_nxt.grace_active    = 1'b0;
      st_nxt.grace           = '0;
      st_nxt.ta_state        = WDG_TA_LOCKED;
      st_nxt.ta_cnt          = 3'h0;
      st_nxt.wake            = 1'b0;
      st_nxt.sys_reset       = 1'b0;
      st_nxt.rdata           = RESET_BYTE;
    end
  end

  always_ff @(posedge clock_i) begin
    st_r <= st_nxt;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign rdata_o     = st_r.rdata;
  assign irq_o       = st_r.timeout_flag && st_r.irq_enable_reg[BIT_TIMEOUT_IRQ];
  assign wake_o      = st_r.wake;
  assign sys_reset_o = st_r.sys_reset;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i || por_i);

  chk_clear_zero: assert property (
    (wr_main_ok && wdata_i[BIT_CLEAR]) |=> (st_r.count == CNT_ZERO) && !st_r.grace_active)
    else $error("counter not zero after clear write");

  chk_disable_stop: assert property (
    (wr_main_ok && !wdata_i[BIT_ENABLE]) |=> !st_r.watchdog_enable ##1 (st_r.count == CNT_ZERO))
    else $error("disable did not stop and zero the counter");

  chk_timeout_flag: assert property (
    timeout |=> st_r.timeout_flag && wake_o ##1 !wake_o)
    else $error("time-out did not set flag and pulse wake");

  chk_irq_gate: assert property (
    (wr_i && addr_i == ADDR_IRQ_ENABLE) |=> irq_o == (st_r.timeout_flag && $past(wdata_i[BIT_TIMEOUT_IRQ])))
    else $error("interrupt request does not follow flag and enable");

  chk_grace_reset: assert property (
    grace_expire |=> sys_reset_o && st_r.watchdog_reset_flag)
    else $error("grace expiry did not reset system");

  chk_no_reset_off: assert property (
    sys_reset_o |-> $past(st_r.grace_active) && $past(st_r.grace) == GRACE_LAST)
    else $error("system reset outside a finished grace window");

  chk_locked_write: assert property (
    (wr_main && !unlocked) |=> $stable(st_r.prescale_select) && $stable(st_r.run_in_low_power))
    else $error("locked write changed the control register");

  chk_lp_hold: assert property (
    (low_power && !st_r.run_in_low_power && $stable(low_power) && !wr_main_ok) |=> $stable(st_r.count))
    else $error("counter moved in low power");

  chk_lp_clear: assert property (
    (low_power != st_r.low_power_prev) |=> (st_r.count == CNT_ZERO))
    else $error("mode change did not zero the counter");

  chk_retained_fields: assert property (@(posedge clock_i) disable iff (por_i)
    reset_i |=> $stable(st_r.prescale_select) && $stable(st_r.reset_on_timeout_enable))
    else $error("retained field lost on non power-on reset");

  chk_enable_load: assert property (@(posedge clock_i) disable iff (1'b0)
    (reset_i || por_i) |=> st_r.watchdog_enable == !$past(config_watchdog_disable_i))
    else $error("enable not loaded from configuration bit");

  // ==========================================================================
  // Counter, flag and access checks
  // ==========================================================================
  chk_count_hold: assert property (
    !st_r.watchdog_enable |=> $stable(st_r.count) || (st_r.count == CNT_ZERO))
    else $error("counter moved while disabled");

  chk_count_step: assert property (
    (run && !clear_req && !timeout) |=> st_r.count == $past(st_r.count) + 14'h0001)
    else $error("counter did not advance on a tick");

  chk_wake_pulse: assert property (
    wake_o |=> !wake_o)
    else $error("wake pulse longer than one cycle");

  chk_flag_sticky: assert property (
    (st_r.timeout_flag && !wr_main_ok) |=> st_r.timeout_flag)
    else $error("time-out flag cleared without a write");

  chk_reset_flag_kept: assert property (@(posedge clock_i) disable iff (por_i)
    (reset_i && !grace_expire && !wr_main_ok) |=> $stable(st_r.watchdog_reset_flag))
    else $error("reset flag lost on non power-on reset");

  chk_por_clear: assert property (@(posedge clock_i) disable iff (1'b0)
    por_i |=> !st_r.watchdog_reset_flag && !st_r.run_in_low_power && !st_r.reset_on_timeout_enable
              && (st_r.prescale_select == PS_RESET))
    else $error("power-on reset did not clear the retained fields");

  chk_grace_cancel: assert property (
    (st_r.grace_active && clear_req) |=> !st_r.grace_active && !sys_reset_o)
    else $error("clear did not cancel the grace window");

  chk_grace_start: assert property (
    (timeout && st_r.reset_on_timeout_enable && !grace_expire) |=> st_r.grace_active)
    else $error("time-out with reset enabled did not open the grace window");

  chk_no_rst_idle: assert property (
    !st_r.grace_active |=> !sys_reset_o)
    else $error("system reset without an open grace window");

  chk_clear_reads_zero: assert property (
    (rd_i && addr_i == ADDR_MAIN_CONTROL) |=> !rdata_o[BIT_CLEAR])
    else $error("clear bit did not read as zero");

  chk_ta_relock: assert property (
    wr_main_ok |=> !unlocked)
    else $error("unlock survived a protected write");

  chk_rst_ctrl_locked: assert property (
    (wr_i && addr_i == ADDR_RESET_CONTROL && !unlocked) |=> $stable(st_r.reset_on_timeout_enable))
    else $error("locked write changed the reset control register");

  chk_tick_single: assert property (
    tick |=> !tick)
    else $error("tick longer than one cycle");

  cov_timeout:     cover property (timeout);
  cov_grace_reset: cover property (grace_expire);
  cov_grace_clear: cover property (st_r.grace_active && wr_main_ok && wdata_i[BIT_CLEAR]);
  cov_lp_wake:     cover property (low_power && wake_o);
  cov_unlock_write: cover property (wr_main_ok);

endmodule : wdg_core

// ### tb/tb_top.sv
// Self-checking testbench for the watchdog core: registers, intervals, grace reset and low power.
// Assumes the core's package and a fast stand-in for the RC clock pin (one period per 8 system clocks).
`timescale 1ns/100ps
module tb_top;
  import wdg_pkg::*;

  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam int TPER = 8;
  localparam int TOL  = 16;
  localparam int DIVS [8] = '{1, 2, 8, 16, 32, 64, 128, 256};

  logic       clock_i;
  logic       reset_i;
  logic       por_i;
  logic       rc_clk_i = 1'b0;
  logic       config_watchdog_disable_i;
  logic       cpu_idle_i;
  logic       cpu_powerdown_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic       irq_o;
  logic       wake_o;
  logic       sys_reset_o;
  logic [1:0] rc_div = 2'h0;
  logic [7:0] v;
  int         n;
  int         c;
  int         rst_cnt = 0;
  int         miscompares;
  int         tests_run;

  wdg_core #(.TA_WINDOW(TA_WINDOW_CYC)) i_wdg_core (
    .clock_i                   (clock_i),
    .reset_i                   (reset_i),
    .por_i                     (por_i),
    .rc_clk_i                  (rc_clk_i),
    .config_watchdog_disable_i (config_watchdog_disable_i),
    .cpu_idle_i                (cpu_idle_i),
    .cpu_powerdown_i           (cpu_powerdown_i),
    .addr_i                    (addr_i),
    .wdata_i                   (wdata_i),
    .wr_i                      (wr_i),
    .rd_i                      (rd_i),
    .rdata_o                   (rdata_o),
    .irq_o                     (irq_o),
    .wake_o                    (wake_o),
    .sys_reset_o               (sys_reset_o)
  );

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  // The RC pin is sped up so that whole time-out and grace periods fit in the run.
  always @(posedge clock_i) begin
    rc_div <= rc_div + 2'h1;
    if (rc_div == 2'h3) rc_clk_i <= ~rc_clk_i;
    if (sys_reset_o === 1'b1) rst_cnt <= rst_cnt + 1;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
    @(posedge clock_i);
  endtask : wr

  task automatic pw(input logic [7:0] a, input logic [7:0] d);
    wr(ADDR_TIMED_ACCESS, TA_KEY_FIRST);
    wr(ADDR_TIMED_ACCESS, TA_KEY_SECOND);
    wr(a, d);
  endtask : pw

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1 d = rdata_o;
    @(posedge clock_i);
  endtask : rd

  // Cycles until wake (sel 0) or reset request (sel 1); maxc plus one when never seen.
  task automatic measure(input bit sel, input int maxc, output int k);
    k = 0;
    while (k <= maxc) begin
      @(posedge clock_i);
      k++;
      if ((sel ? sys_reset_o : wake_o) === 1'b1) break;
    end
  endtask : measure

  task automatic win(input int k, input int exp);
    chk({7'h0, (k >= exp - TOL) && (k <= exp + TOL)}, 8'h01);
  endtask : win

  task automatic do_reset(input bit por, input bit cfg);
    config_watchdog_disable_i <= cfg;
    if (por) por_i <= 1'b1;
    else reset_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    por_i   <= 1'b0;
    reset_i <= 1'b0;
    @(posedge clock_i);
  endtask : do_reset

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs;
    rd(ADDR_MAIN_CONTROL, v);   chk(v, 8'h80);
    rd(ADDR_RESET_CONTROL, v);  chk(v, 8'h00);
    rd(ADDR_IRQ_ENABLE, v);     chk(v, 8'h00);
    rd(8'h10, v);               chk(v, 8'h00);
    wr(ADDR_RESET_CONTROL, 8'h01);
    rd(ADDR_RESET_CONTROL, v);  chk(v, 8'h00);
    wr(ADDR_MAIN_CONTROL, 8'h00);
    rd(ADDR_MAIN_CONTROL, v);   chk(v, 8'h80);
    wr(ADDR_TIMED_ACCESS, TA_KEY_FIRST);
    wr(ADDR_TIMED_ACCESS, TA_KEY_SECOND);
    repeat (6) @(posedge clock_i);
    wr(ADDR_MAIN_CONTROL, 8'h00);
    rd(ADDR_MAIN_CONTROL, v);   chk(v, 8'h80);
    pw(ADDR_MAIN_CONTROL, 8'h00);
    rd(ADDR_MAIN_CONTROL, v);   chk(v, 8'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_intervals;
    for (int code = 0; code < 5; code++) begin
      pw(ADDR_MAIN_CONTROL, 8'hc0 | 8'(code));
      measure(0, 64 * DIVS[code] * TPER + 100, n);
      win(n, 64 * DIVS[code] * TPER);
      rd(ADDR_MAIN_CONTROL, v);
      chk(v, 8'ha0 | 8'(code));
      if (code == 0) begin
        chk({7'h0, irq_o}, 8'h00);
        wr(ADDR_IRQ_ENABLE, 8'h10);
        chk({7'h0, irq_o}, 8'h01);
        pw(ADDR_MAIN_CONTROL, 8'h80);
        chk({7'h0, irq_o}, 8'h00);
        rd(ADDR_MAIN_CONTROL, v);
        chk(v, 8'h80);
        wr(ADDR_IRQ_ENABLE, 8'h00);
      end
    end
    pw(ADDR_MAIN_CONTROL, 8'h00);
    $display("test intervals done");
  endtask : t_intervals

  task automatic t_cancel;
    pw(ADDR_RESET_CONTROL, 8'h01);
    pw(ADDR_MAIN_CONTROL, 8'hc0);
    measure(0, 64 * TPER + 100, n);
    repeat (200) @(posedge clock_i);
    c = rst_cnt;
    pw(ADDR_MAIN_CONTROL, 8'hc0);
    measure(0, 64 * TPER + 100, n);
    win(n, 64 * TPER);
    chk(8'(rst_cnt - c), 8'h00);
    pw(ADDR_MAIN_CONTROL, 8'h00);
    pw(ADDR_RESET_CONTROL, 8'h00);
    $display("test cancel done");
  endtask : t_cancel

  task automatic t_lowpower;
    pw(ADDR_MAIN_CONTROL, 8'hc0);
    repeat (30 * TPER) @(posedge clock_i);
    cpu_idle_i <= 1'b1;
    measure(0, 100 * TPER, n);
    chk({7'h0, n > 100 * TPER}, 8'h01);
    cpu_idle_i <= 1'b0;
    measure(0, 64 * TPER + 100, n);
    win(n, 64 * TPER);
    pw(ADDR_MAIN_CONTROL, 8'hd0);
    repeat (30 * TPER) @(posedge clock_i);
    cpu_powerdown_i <= 1'b1;
    measure(0, 64 * TPER + 100, n);
    win(n, 64 * TPER);
    cpu_powerdown_i <= 1'b0;
    pw(ADDR_MAIN_CONTROL, 8'hc0);
    repeat (40 * TPER) @(posedge clock_i);
    pw(ADDR_MAIN_CONTROL, 8'h00);
    pw(ADDR_MAIN_CONTROL, 8'h80);
    measure(0, 64 * TPER + 100, n);
    win(n, 64 * TPER);
    pw(ADDR_MAIN_CONTROL, 8'h00);
    $display("test lowpower done");
  endtask : t_lowpower

  task automatic t_grace;
    pw(ADDR_RESET_CONTROL, 8'h01);
    pw(ADDR_MAIN_CONTROL, 8'hd1);
    measure(0, 128 * TPER + 100, n);
    win(n, 128 * TPER);
    measure(1, GRACE_TICKS * TPER + 100, n);
    win(n, GRACE_TICKS * TPER);
    rd(ADDR_MAIN_CONTROL, v);   chk(v, 8'hb9);
    do_reset(0, 1'b1);
    rd(ADDR_MAIN_CONTROL, v);   chk(v, 8'h19);
    rd(ADDR_RESET_CONTROL, v);  chk(v, 8'h01);
    do_reset(1, 1'b1);
    rd(ADDR_MAIN_CONTROL, v);   chk(v, 8'h00);
    rd(ADDR_RESET_CONTROL, v);  chk(v, 8'h00);
    $display("test grace done");
  endtask : t_grace

  // ==========================================================================
  // Sequence and verdict
  // ==========================================================================
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  initial begin
    miscompares = 0;
    tests_run = 0;
    por_i = 1'b1;
    reset_i = 1'b1;
    config_watchdog_disable_i = 1'b0;
    cpu_idle_i = 1'b0;
    cpu_powerdown_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    repeat (5) @(posedge clock_i);
    por_i <= 1'b0;
    reset_i <= 1'b0;
    @(posedge clock_i);
    t_regs;
    t_intervals;
    t_cancel;
    t_lowpower;
    t_grace;
    conclude;
  end

  // The full sequence needs about 40000 cycles; this limit stops a hang at 80000.
  initial begin
    #8_000_000;
    miscompares++;
    conclude;
  end

endmodule : tb_top
